// >>> bench/ctrl_model.sv
// partner model: serial bus controller issuing one link request at a time
`timescale 1ns/1ps
module ctrl_model (
  input wire logic link_clk_i,  // link clock
  input wire logic busy_i,      // request in flight
  input wire logic done_i,      // answer pulse
  input wire logic [15:0] rdata_i,  // answer word
  output logic [1:0] ptr_o,     // register pointer
  output logic wr_o,            // write pulse
  output logic rd_o,            // read pulse
  output logic resp_o,          // alert response pulse
  output logic [15:0] wdata_o   // write data
);
  initial begin
    {wr_o, rd_o, resp_o} = 3'h0;
    ptr_o = 2'h0;
    wdata_o = 16'h0000;
  end
  // one request, held for the taking edge, answer sampled at the done edge
  task automatic xfer(input thr_pkg::req_kind_t k, input logic [1:0] p, input logic [15:0] d,
                      output logic [15:0] q);
    int i;
    logic b;
    i = 0;
    b = 1'b0;
    @(negedge link_clk_i);
    ptr_o = p;
    wdata_o = d;
    wr_o = (k == thr_pkg::REQ_WRITE);
    rd_o = (k == thr_pkg::REQ_READ);
    resp_o = (k == thr_pkg::REQ_ALERT_RESP);
    @(posedge link_clk_i);
    @(negedge link_clk_i);
    b = busy_i;  // request must show as taken
    {wr_o, rd_o, resp_o} = 3'h0;
    ptr_o = ~p;
    wdata_o = ~d;  // released lines show junk, not the old value
    do @(posedge link_clk_i); while (done_i !== 1'b1 && ++i < 40);
    // busy after the take, idle at the answer; anything else gives a marker
    q = (done_i === 1'b1 && b === 1'b1 && busy_i === 1'b0) ? rdata_i : 16'hDEAD;
  endtask
endmodule

// >>> bench/threshold_alert_comparator_tb.sv
// testbench: limit comparator, alert pin and limit registers over the link
`timescale 1ns/1ps
module threshold_alert_comparator_tb;
  typedef struct {logic p; logic [1:0] q; logic w; logic [15:0] r; int n; logic e, e0;} row_t;
  logic clk = 1'b0;  // core clock
  logic lclk = 1'b0;  // link clock
  logic rst_n = 1'b0;  // reset
  logic conv, flag, single, win, pol, lat, busy, done, wr, rd, resp, oe, ao, line;
  logic [1:0] que, ptr;
  logic [15:0] res, wdata, rdata, q;
  logic [6:0] addr = 7'h4B;  // address strap
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  // polarity, queue, window, result, conversions, pin after, pin before last
  row_t rows [7] = '{'{1'b0, 2'h0, 1'b0, 16'h00C8, 1, 1'b0, 1'b1},
    '{1'b1, 2'h0, 1'b0, 16'h00C8, 1, 1'b1, 1'b0}, '{1'b0, 2'h1, 1'b0, 16'h00C8, 2, 1'b0, 1'b1},
    '{1'b0, 2'h2, 1'b0, 16'h00C8, 4, 1'b0, 1'b1}, '{1'b0, 2'h3, 1'b0, 16'h00C8, 4, 1'b1, 1'b1},
    '{1'b0, 2'h0, 1'b1, 16'hFF38, 1, 1'b0, 1'b1}, '{1'b0, 2'h0, 1'b0, 16'hFF38, 1, 1'b1, 1'b1}};
  assign line = ~oe;  // pull-up unless the pin drives low
  always #20 clk = ~clk;
  initial #1.3 forever #3 lclk = ~lclk;
  threshold_alert_comparator #(.RDY_PULSE_CYCLES(2)) i_dut (.CLK_I(clk), .RESET_N_I(rst_n),
    .LINK_CLK_I(lclk), .LINK_PTR_I(ptr), .LINK_WR_I(wr), .LINK_RD_I(rd),
    .LINK_ALERT_RESP_I(resp), .LINK_WDATA_I(wdata), .LINK_BUSY_O(busy), .LINK_DONE_O(done),
    .LINK_RDATA_O(rdata), .CONV_DONE_I(conv), .CONV_RESULT_I(res),
    .CONVERSION_STATUS_FLAG_I(flag), .MODE_SINGLE_I(single), .WINDOW_MODE_I(win),
    .ALERT_POLARITY_I(pol), .ALERT_LATCH_ENABLE_I(lat), .ALERT_QUEUE_COUNT_I(que),
    .DEV_ADDR_I(addr), .ALERT_I(line), .ALERT_O(ao), .ALERT_OE_O(oe));
  ctrl_model i_ctrl (.link_clk_i(lclk), .busy_i(busy), .done_i(done), .rdata_i(rdata),
    .ptr_o(ptr), .wr_o(wr), .rd_o(rd), .resp_o(resp), .wdata_o(wdata));
  task automatic final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic pin(input logic e);
    chk({14'h0000, ao, line}, {14'h0000, 1'b0, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cv(input logic [15:0] r);
    @(negedge clk);
    conv = 1'b1;
    res = r;
    @(negedge clk);
    conv = 1'b0;
    res = ~r;
    tick(3);
  endtask
  task automatic do_reset;
    @(negedge clk);
    rst_n = 1'b0;
    tick(20);
    rst_n = 1'b1;
    tick(2);
  endtask
  // both limits are always written together, low before high
  task automatic lims(input logic [15:0] lo, input logic [15:0] hi);
    i_ctrl.xfer(thr_pkg::REQ_WRITE, thr_pkg::PTR_LOW, lo, q);
    chk(q, lo);
    i_ctrl.xfer(thr_pkg::REQ_WRITE, thr_pkg::PTR_HIGH, hi, q);
    i_ctrl.xfer(thr_pkg::REQ_READ, thr_pkg::PTR_HIGH, 16'h0000, q);
    chk(q, hi);
  endtask
  initial begin
    {conv, flag, single, win, pol, lat} = 6'h00;
    que = 2'h0;
    res = 16'h0000;
    do_reset();
    i_ctrl.xfer(thr_pkg::REQ_READ, thr_pkg::PTR_LOW, 16'h0000, q);
    chk(q, 16'h8000);
    i_ctrl.xfer(thr_pkg::REQ_READ, thr_pkg::PTR_HIGH, 16'h0000, q);
    chk(q, 16'h7FFF);
    for (int i = 0; i < 7; i++) begin
      tick(1);
      {pol, que, win} = {rows[i].p, rows[i].q, rows[i].w};
      do_reset();
      lims(16'hFF9C, 16'h0064);
      for (int k = 1; k <= rows[i].n; k++) begin
        if (k == rows[i].n) pin(rows[i].e0);
        cv(rows[i].r);
      end
      pin(rows[i].e);
      $display("row %0d done", i);
    end
    cv(16'h00C8);
    cv(16'h0000);
    pin(1'b0);
    cv(16'hFF38);
    pin(1'b1);
    win = 1'b1;
    cv(16'h00C8);
    cv(16'h0000);
    pin(1'b1);
    lat = 1'b1;
    cv(16'hFF38);
    cv(16'h0000);
    pin(1'b0);
    i_ctrl.xfer(thr_pkg::REQ_ALERT_RESP, thr_pkg::PTR_RESULT, 16'h0000, q);
    chk(q, 16'h00CB);
    tick(3);
    pin(1'b1);
    cv(16'h00C8);
    i_ctrl.xfer(thr_pkg::REQ_READ, thr_pkg::PTR_RESULT, 16'h0000, q);
    chk(q, 16'h00C8);
    tick(3);
    pin(1'b1);
    $display("latch tests done");
    lat = 1'b0;
    lims(16'h0000, 16'h8000);
    tick(1);
    single = 1'b1;
    flag = 1'b1;
    tick(3);
    pin(1'b0);
    flag = 1'b0;
    tick(3);
    pin(1'b1);
    single = 1'b0;
    @(negedge clk);
    conv = 1'b1;
    @(negedge clk);
    conv = 1'b0;
    tick(2);
    pin(1'b0);
    tick(3);
    pin(1'b1);
    $display("ready tests done");
    addr = 7'h21;
    do_reset();
    i_ctrl.xfer(thr_pkg::REQ_ALERT_RESP, thr_pkg::PTR_RESULT, 16'h0000, q);
    chk(q, 16'h0121);
    $display("address test done");
    final_report();
  end
endmodule

// >>> logic/link_side.sv
// module: link clock domain request capture and answer return
`timescale 1ns/1ps
module link_side (
  input wire logic link_clk_i,                     // link clock
  input wire logic reset_n_i,                      // async reset, active low
  input wire logic [1:0] ptr_i,                    // register pointer
  input wire logic wr_i,                           // write request pulse
  input wire logic rd_i,                           // read request pulse
  input wire logic resp_i,                         // alert response pulse
  input wire logic [15:0] wdata_i,                 // write data
  output logic busy_o,                             // request in flight
  output logic done_o,                             // answer pulse
  output logic [15:0] rdata_o,                     // answer data
  link_if.link_end bus                             // crossing to core
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,                               // ready for a request
    ST_WAIT = 2'b10                                // waiting for answer
  } link_state_t;
  link_state_t state_q, state_d;                   // handshake state
  logic ack_s1_q, ack_s2_q, ack_s3_q;              // answer toggle synchroniser
  logic ack_seen_q;                                // last answer toggle taken
  logic req_tgl_q;                                 // request toggle
  thr_pkg::req_kind_t kind_q;                      // held kind
  logic [1:0] ptr_q;                               // held pointer
  logic [15:0] wdata_q;                            // held write data
  logic [15:0] rdata_q;                            // answer data register
  logic done_q;                                    // answer pulse register
  wire any_req = wr_i | rd_i | resp_i;             // any request this edge
  wire take = (state_q == ST_IDLE) && any_req;     // request accepted
  wire ack_new = (ack_s2_q == ack_s3_q) && (ack_s3_q != ack_seen_q); // answer arrived
  wire thr_pkg::req_kind_t kind_d = wr_i ? thr_pkg::REQ_WRITE :
                                    (rd_i ? thr_pkg::REQ_READ : thr_pkg::REQ_ALERT_RESP);
  // next state: a request waits for its answer, others are ignored meanwhile
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (ack_new) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end
  // state and answer toggle synchroniser
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      ack_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ack_s1_q <= bus.ack_tgl;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      if (ack_new) begin
        ack_seen_q <= ack_s3_q;
      end
    end
  end
  // request hold registers, stable while the core samples them
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_tgl_q <= 1'b0;
      kind_q <= thr_pkg::REQ_READ;
      ptr_q <= thr_pkg::PTR_RESULT;
      wdata_q <= thr_pkg::ZERO_WORD;
    end else if (take) begin
      req_tgl_q <= ~req_tgl_q;
      kind_q <= kind_d;
      ptr_q <= ptr_i;
      wdata_q <= wdata_i;
    end
  end
  // answer capture and one-cycle done pulse
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= thr_pkg::ZERO_WORD;
      done_q <= 1'b0;
    end else begin
      done_q <= ack_new && (state_q == ST_WAIT);
      if (ack_new) begin
        rdata_q <= bus.ack_data;
      end
    end
  end
  assign bus.req_tgl = req_tgl_q;
  assign bus.req_kind = kind_q;
  assign bus.req_ptr = ptr_q;
  assign bus.req_wdata = wdata_q;
  assign busy_o = (state_q != ST_IDLE);
  assign done_o = done_q;
  assign rdata_o = rdata_q;
endmodule

// >>> logic/threshold_alert_comparator.sv
// module: digital limit comparator and alert / conversion-ready pin logic
//
// Overview of operation
// - polarity bit zero gives active-low pin
// - non-latching alert releases on an in-range result (window) or a result below low (traditional)
// - latching alert holds until read or response
// - alert response returns own bus address
// - queue code 11 disables comparator, pin floats
// - assert after one, two or four faults
// - two 16-bit signed limit registers
// - high MSB one, low MSB zero: ready
// - single-shot ready mode mirrors status flag
// - continuous ready mode pulses per result
// - low limit at pointer 2, resets 8000h
// - high limit at pointer 3, resets 7FFFh
// - window bit selects traditional or window
// - mode bit selects continuous or single-shot
`timescale 1ns/1ps
module threshold_alert_comparator #(
  parameter int RDY_PULSE_CYCLES = 2               // ready pulse length in clocks
) (
  input wire logic CLK_I,                          // core clock, 25 MHz
  input wire logic RESET_N_I,                      // async reset, active low
  input wire logic LINK_CLK_I,                     // serial link clock
  input wire logic [1:0] LINK_PTR_I,               // register pointer
  input wire logic LINK_WR_I,                      // write request pulse
  input wire logic LINK_RD_I,                      // read request pulse
  input wire logic LINK_ALERT_RESP_I,              // alert response pulse
  input wire logic [15:0] LINK_WDATA_I,            // write data
  output logic LINK_BUSY_O,                        // request in flight
  output logic LINK_DONE_O,                        // answer pulse
  output logic [15:0] LINK_RDATA_O,                // answer data
  input wire logic CONV_DONE_I,                    // result ready pulse
  input wire logic [15:0] CONV_RESULT_I,           // signed conversion result
  input wire logic CONVERSION_STATUS_FLAG_I,       // conversion status flag
  input wire logic MODE_SINGLE_I,                  // operating mode bit
  input wire logic WINDOW_MODE_I,                  // window select bit
  input wire logic ALERT_POLARITY_I,               // alert_polarity bit
  input wire logic ALERT_LATCH_ENABLE_I,           // alert_latch_enable bit
  input wire logic [1:0] ALERT_QUEUE_COUNT_I,      // alert_queue_count field
  input wire logic [6:0] DEV_ADDR_I,               // address strap
  input wire logic ALERT_I,                        // shared alert line level
  output logic ALERT_O,                            // pin drive value
  output logic ALERT_OE_O                          // pin drive enable
);
  localparam int RDY_W = $clog2(RDY_PULSE_CYCLES + 1); // ready counter width
  localparam logic [RDY_W-1:0] RDY_LOAD = RDY_W'(RDY_PULSE_CYCLES); // pulse load
  localparam logic [RDY_W-1:0] RDY_ZERO = '0;      // pulse idle
  localparam logic [RDY_W-1:0] RDY_STEP = RDY_W'(1); // pulse decrement

  link_if xing ();                                 // domain crossing bundle

  // link domain request capture
  link_side u_link (
    .link_clk_i (LINK_CLK_I),
    .reset_n_i (RESET_N_I),
    .ptr_i (LINK_PTR_I),
    .wr_i (LINK_WR_I),
    .rd_i (LINK_RD_I),
    .resp_i (LINK_ALERT_RESP_I),
    .wdata_i (LINK_WDATA_I),
    .busy_o (LINK_BUSY_O),
    .done_o (LINK_DONE_O),
    .rdata_o (LINK_RDATA_O),
    .bus (xing.link_end)
  );

  // fault run needed for each queue code
  function automatic logic [2:0] need_of(input logic [1:0] q);
    logic [2:0] n;
    n = thr_pkg::NEED_FOUR;
    if (q == thr_pkg::QUEUE_ONE) begin
      n = thr_pkg::NEED_ONE;
    end else if (q == thr_pkg::QUEUE_TWO) begin
      n = thr_pkg::NEED_TWO;
    end
    return n;
  endfunction

  logic req_s1_q, req_s2_q, req_s3_q;              // request toggle synchroniser
  logic req_seen_q;                                // last request toggle taken
  logic ack_tgl_q;                                 // answer toggle
  logic [15:0] ack_data_q;                         // answer word
  logic line_s1_q, line_s2_q, line_s3_q;           // alert line synchroniser
  logic line_q;                                    // filtered alert line level
  logic [6:0] addr_q;                              // captured strap address
  logic addr_taken_q;                              // strap captured
  logic [15:0] low_q;                              // low_limit register
  logic [15:0] high_q;                             // high_limit register
  logic [15:0] result_q;                           // stored conversion result
  logic [2:0] cnt_q;                               // consecutive fault count
  logic alert_q;                                   // comparator alert state
  logic [RDY_W-1:0] rdy_cnt_q;                     // ready pulse countdown
  logic pin_oe_q;                                  // pin drive enable register

  // request arrives once the second and third stages agree on a new toggle
  wire req_new = (req_s2_q == req_s3_q) && (req_s3_q != req_seen_q);
  wire kind_wr = (xing.req_kind == thr_pkg::REQ_WRITE);
  wire kind_rd = (xing.req_kind == thr_pkg::REQ_READ);
  wire kind_resp = (xing.req_kind == thr_pkg::REQ_ALERT_RESP);
  wire wr_low = req_new && kind_wr && (xing.req_ptr == thr_pkg::PTR_LOW);
  wire wr_high = req_new && kind_wr && (xing.req_ptr == thr_pkg::PTR_HIGH);
  wire read_result = req_new && kind_rd && (xing.req_ptr == thr_pkg::PTR_RESULT);
  wire resp_evt = req_new && kind_resp;

  // mode decode
  wire rdy_mode = high_q[thr_pkg::DATA_MSB] && !low_q[thr_pkg::DATA_MSB];
  wire queue_dis = (ALERT_QUEUE_COUNT_I == thr_pkg::QUEUE_DISABLE);
  wire cmp_on = !queue_dis && !rdy_mode;           // comparator active
  wire window = (WINDOW_MODE_I != thr_pkg::WIN_TRADITIONAL);
  wire continuous = (MODE_SINGLE_I == thr_pkg::MODE_CONTINUOUS);

  // signed comparison against the limits, same cycle as the result is stored
  wire above = $signed(CONV_RESULT_I) > $signed(high_q);
  wire below = $signed(CONV_RESULT_I) < $signed(low_q);
  wire fault = window ? (above || below) : above;
  wire back_in = window ? !fault : below;
  wire [2:0] need = need_of(ALERT_QUEUE_COUNT_I);
  wire [2:0] cnt_inc = (cnt_q >= need) ? cnt_q : 3'(cnt_q + thr_pkg::CNT_STEP);
  wire [2:0] cnt_d = (CONV_DONE_I && cmp_on) ? (fault ? cnt_inc : thr_pkg::CNT_ZERO) :
                     (cmp_on ? cnt_q : thr_pkg::CNT_ZERO);
  wire set_evt = CONV_DONE_I && cmp_on && fault && (cnt_inc >= need);
  wire latch_clr = ALERT_LATCH_ENABLE_I && (read_result || resp_evt);
  wire conv_clr = CONV_DONE_I && back_in && !ALERT_LATCH_ENABLE_I;
  wire clr_evt = latch_clr || conv_clr || !cmp_on;
  wire alert_d = set_evt ? 1'b1 : (clr_evt ? 1'b0 : alert_q); // set wins over clear

  // ready pulse countdown for continuous conversions
  wire rdy_load = CONV_DONE_I && rdy_mode && continuous;
  wire [RDY_W-1:0] rdy_cnt_d = rdy_load ? RDY_LOAD :
                               ((rdy_cnt_q != RDY_ZERO) ? RDY_W'(rdy_cnt_q - RDY_STEP) : RDY_ZERO);

  // pin level: asserted state through the polarity bit, open drain pulls low
  wire rdy_level = continuous ? (rdy_cnt_q != RDY_ZERO) : CONVERSION_STATUS_FLAG_I;
  wire asserted = rdy_mode ? rdy_level : alert_q;
  wire pin_high = asserted ^ (ALERT_POLARITY_I == thr_pkg::POL_ACTIVE_LOW);
  wire pin_oe_d = !queue_dis && !pin_high;

  // answer word for each request
  wire [15:0] resp_word = {7'h00, line_q, asserted, addr_q};
  wire [15:0] read_word = (xing.req_ptr == thr_pkg::PTR_LOW) ? low_q :
                          (xing.req_ptr == thr_pkg::PTR_HIGH) ? high_q :
                          (xing.req_ptr == thr_pkg::PTR_RESULT) ? result_q : thr_pkg::ZERO_WORD;
  wire [15:0] ack_data_d = kind_resp ? resp_word : (kind_wr ? xing.req_wdata : read_word);

  // request toggle and shared line synchronisers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
      line_s3_q <= 1'b1;
      line_q <= 1'b1;
    end else begin
      req_s1_q <= xing.req_tgl;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      line_s1_q <= ALERT_I;
      line_s2_q <= line_s1_q;
      line_s3_q <= line_s2_q;
      if (line_s2_q == line_s3_q) begin
        line_q <= line_s3_q;
      end
    end
  end

  // request acceptance and answer return
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      req_seen_q <= 1'b0;
      ack_tgl_q <= 1'b0;
      ack_data_q <= thr_pkg::ZERO_WORD;
    end else if (req_new) begin
      req_seen_q <= req_s3_q;
      ack_tgl_q <= ~ack_tgl_q;
      ack_data_q <= ack_data_d;
    end
  end

  // address strap caught on the first edge after reset release
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      addr_q <= 7'h00;
      addr_taken_q <= 1'b0;
    end else if (!addr_taken_q) begin
      addr_q <= DEV_ADDR_I;
      addr_taken_q <= 1'b1;
    end
  end

  // limit registers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      low_q <= thr_pkg::LOW_RESET;
      high_q <= thr_pkg::HIGH_RESET;
    end else begin
      if (wr_low) begin
        low_q <= xing.req_wdata;
      end
      if (wr_high) begin
        high_q <= xing.req_wdata;
      end
    end
  end

  // result store, fault counter and alert state
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      result_q <= thr_pkg::ZERO_WORD;
      cnt_q <= thr_pkg::CNT_ZERO;
      alert_q <= 1'b0;
    end else begin
      if (CONV_DONE_I) begin
        result_q <= CONV_RESULT_I;
      end
      cnt_q <= cnt_d;
      alert_q <= alert_d;
    end
  end

  // ready pulse and pin drive registers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rdy_cnt_q <= RDY_ZERO;
      pin_oe_q <= 1'b0;
    end else begin
      rdy_cnt_q <= rdy_cnt_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign xing.ack_tgl = ack_tgl_q;
  assign xing.ack_data = ack_data_q;
  assign ALERT_O = 1'b0;                           // open drain only pulls low
  assign ALERT_OE_O = pin_oe_q;

  // checks in the core clock domain
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  a_queue_disable_float: assert property (queue_dis |=> !ALERT_OE_O)
    else $error("pin driven while comparator disabled");
  a_polarity_low_drive: assert property ((!queue_dis && !rdy_mode && alert_q &&
      ALERT_POLARITY_I == thr_pkg::POL_ACTIVE_LOW) |=> ALERT_OE_O)
    else $error("active-low alert not pulling pin");
  a_polarity_high_drive: assert property ((!queue_dis && !rdy_mode && alert_q &&
      ALERT_POLARITY_I != thr_pkg::POL_ACTIVE_LOW) |=> !ALERT_OE_O)
    else $error("active-high alert pulling pin low");
  a_nonlatch_release: assert property ((CONV_DONE_I && cmp_on && !fault && window &&
      !ALERT_LATCH_ENABLE_I) |=> !alert_q)
    else $error("non-latching alert kept after in-range result");
  a_latch_hold: assert property ((alert_q && ALERT_LATCH_ENABLE_I && cmp_on &&
      !read_result && !resp_evt) |=> alert_q)
    else $error("latched alert released without read or response");
  a_resp_address: assert property (resp_evt |=> ack_data_q[6:0] == addr_q &&
      ack_data_q[thr_pkg::RESP_ACTIVE_BIT] == $past(asserted) &&
      ack_data_q[thr_pkg::RESP_LINE_BIT] == $past(line_q))
    else $error("alert response word wrong");
  a_queue_one_fault: assert property ((CONV_DONE_I && cmp_on && fault &&
      ALERT_QUEUE_COUNT_I == thr_pkg::QUEUE_ONE) |=> alert_q)
    else $error("alert not raised after one fault");
  a_queue_two_wait: assert property ((CONV_DONE_I && cmp_on && fault && !alert_q &&
      cnt_q == thr_pkg::CNT_ZERO && ALERT_QUEUE_COUNT_I == thr_pkg::QUEUE_TWO) |=> !alert_q)
    else $error("alert raised on first of two faults");
  a_count_bound: assert property (cnt_q <= thr_pkg::NEED_FOUR)
    else $error("fault counter beyond four");
  a_low_write: assert property (wr_low |=> low_q == $past(xing.req_wdata))
    else $error("low limit write lost");
  a_high_write: assert property (wr_high |=> high_q == $past(xing.req_wdata))
    else $error("high limit write lost");
  a_ready_single: assert property ((rdy_mode && !continuous && !queue_dis) |=>
      ALERT_OE_O == ($past(CONVERSION_STATUS_FLAG_I) ^ $past(ALERT_POLARITY_I)))
    else $error("ready pin does not follow status flag");
  a_ready_pulse: assert property (rdy_load |=> rdy_cnt_q == RDY_LOAD ##1
      rdy_cnt_q >= RDY_LOAD - RDY_STEP)
    else $error("ready pulse not started");
  a_ready_no_alert: assert property (rdy_mode |=> !alert_q)
    else $error("comparator alert in ready mode");
  a_result_store: assert property (CONV_DONE_I |=> result_q == $past(CONV_RESULT_I))
    else $error("result not stored");

  c_latched_alert: cover property (alert_q && ALERT_LATCH_ENABLE_I ##1 read_result);
  c_window_fault: cover property (CONV_DONE_I && window && below && cmp_on);
  c_ready_pulse: cover property (rdy_load ##1 ALERT_OE_O);
  c_alert_resp: cover property (resp_evt && asserted);
endmodule

// >>> pkg/link_if.sv
// interface: request and answer toggle handshake between link and core domains
`timescale 1ns/1ps
interface link_if;
  logic req_tgl;                                   // flips once per request
  thr_pkg::req_kind_t req_kind;                    // held while request pending
  logic [1:0] req_ptr;                             // register pointer
  logic [15:0] req_wdata;                          // write data
  logic ack_tgl;                                   // flips once per answer
  logic [15:0] ack_data;                           // answer word, held
  modport link_end (output req_tgl, req_kind, req_ptr, req_wdata, input ack_tgl, ack_data);
  modport core_end (input req_tgl, req_kind, req_ptr, req_wdata, output ack_tgl, ack_data);
endinterface

// >>> pkg/thr_pkg.sv
// package: register pointers, reset values, field codes and request kinds of the comparator
package thr_pkg;
  localparam int DATA_W = 16;                      // result and limit width
  localparam int ADDR_W = 7;                       // device bus address width
  localparam int CNT_W = 3;                        // consecutive fault counter width
  localparam int DATA_MSB = 15;                    // sign bit position of limits
  localparam int RESP_ACTIVE_BIT = 7;              // alert response: pin asserted flag
  localparam int RESP_LINE_BIT = 8;                // alert response: shared line level
  localparam logic [1:0] PTR_RESULT = 2'h0;        // conversion result pointer
  localparam logic [1:0] PTR_CONFIG = 2'h1;        // config pointer, held outside
  localparam logic [1:0] PTR_LOW = 2'h2;           // low limit pointer
  localparam logic [1:0] PTR_HIGH = 2'h3;          // high limit pointer
  localparam logic [15:0] LOW_RESET = 16'h8000;    // low limit after reset
  localparam logic [15:0] HIGH_RESET = 16'h7FFF;   // high limit after reset
  localparam logic [15:0] ZERO_WORD = 16'h0000;    // cleared word
  localparam logic [1:0] QUEUE_ONE = 2'h0;         // assert after one fault
  localparam logic [1:0] QUEUE_TWO = 2'h1;         // assert after two faults
  localparam logic [1:0] QUEUE_FOUR = 2'h2;        // assert after four faults
  localparam logic [1:0] QUEUE_DISABLE = 2'h3;     // comparator off, pin released
  localparam logic [2:0] NEED_ONE = 3'h1;          // fault run lengths
  localparam logic [2:0] NEED_TWO = 3'h2;
  localparam logic [2:0] NEED_FOUR = 3'h4;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_STEP = 3'h1;
  localparam logic POL_ACTIVE_LOW = 1'b0;          // polarity bit reset value
  localparam logic MODE_CONTINUOUS = 1'b0;         // operating mode bit: continuous
  localparam logic WIN_TRADITIONAL = 1'b0;         // window select: traditional
  typedef enum logic [1:0] {
    REQ_WRITE = 2'h0,                              // write a limit register
    REQ_READ = 2'h1,                               // read a register
    REQ_ALERT_RESP = 2'h2                          // bus alert response
  } req_kind_t;
endpackage
